// [fdsc_regs.vh]
/*
 Constants for the float dispatch and speculation controller.
 Assumes inclusion by the single design file; definitions only.
*/
`ifndef FDSC_REGS_VH
`define FDSC_REGS_VH
`define FDSC_DEPTH      3'h4
`define FDSC_PTR_W      2
`define FDSC_CNT_W      3
`define FDSC_DATA_W     64
`define FDSC_INSN_W     32
`define FDSC_ADDR_W     32
`define FDSC_STATE_W    64
`define FDSC_RUN        2'h0
`define FDSC_HALT       2'h1
`define FDSC_RESTORE    2'h2
`endif

// [fdsc_ctrl.v]
/*
 Float dispatch and speculation controller: float queue, checkpoints,
 speculation level and an ordered speculative write buffer.
 Assumes the integer pipeline holds each request until accepted and
 the float unit reports completion and faults in queue order.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fdsc_regs.vh"
module fdsc_ctrl (
    // Clock and reset
    input  wire                        clk,
    input  wire                        arst_n,
    // Address calc stage two request
    input  wire                        ac2_valid,
    input  wire                        ac2_primary_pipe,
    input  wire                        ac2_xlate_fault,
    input  wire [`FDSC_INSN_W-1:0]     ac2_insn,
    input  wire [`FDSC_DATA_W-1:0]     ac2_operand,
    input  wire [`FDSC_STATE_W-1:0]    ac2_state,
    output reg                         ac2_accept_ff,
    output reg                         ac2_fault_ff,
    // Decode side stop conditions
    input  wire                        dec_branch_or_float,
    input  wire                        dec_unsaved_write,
    input  wire                        dec_fault,
    output reg                         spec_halt_ff,
    output reg  [`FDSC_CNT_W-1:0]      spec_level_ff,
    // Speculative integer writes
    input  wire                        wr_valid,
    input  wire [`FDSC_ADDR_W-1:0]     wr_addr,
    input  wire [`FDSC_DATA_W-1:0]     wr_data,
    output reg                         wr_accept_ff,
    // Float unit
    output reg                         float_unit_valid_ff,
    output reg  [`FDSC_INSN_W-1:0]     float_unit_insn_ff,
    output reg  [`FDSC_DATA_W-1:0]     float_unit_operand_ff,
    input  wire                        float_unit_ready,
    input  wire                        float_unit_done,
    input  wire                        float_unit_exc,
    // Ordered external writes
    output reg                         ext_wr_valid_ff,
    output reg  [`FDSC_ADDR_W-1:0]     ext_wr_addr_ff,
    output reg  [`FDSC_DATA_W-1:0]     ext_wr_data_ff,
    input  wire                        ext_wr_ready,
    // Restore and exception report
    output reg                         restore_ff,
    output reg  [`FDSC_STATE_W-1:0]    restore_state_ff,
    output reg                         exc_report_ff
);
    // Speculation states
    localparam [1:0] ST_RUN     = `FDSC_RUN;
    localparam [1:0] ST_HALT    = `FDSC_HALT;
    localparam [1:0] ST_RESTORE = `FDSC_RESTORE;

    // Float queue, checkpoints and write buffer entries
    reg  [`FDSC_INSN_W-1:0]  q_insn_ff  [0:3];
    reg  [`FDSC_DATA_W-1:0]  q_opnd_ff  [0:3];
    reg  [`FDSC_STATE_W-1:0] ckpt_ff    [0:3];
    reg  [`FDSC_ADDR_W-1:0]  wb_addr_ff [0:3];
    reg  [`FDSC_DATA_W-1:0]  wb_data_ff [0:3];
    reg  [`FDSC_CNT_W-1:0]   wb_tag_ff  [0:3];

    // Pointers, counters and state
    reg  [`FDSC_PTR_W-1:0]   q_wr_ff;
    reg  [`FDSC_PTR_W-1:0]   q_rd_ff;
    reg  [`FDSC_PTR_W-1:0]   q_sent_ff;
    reg  [`FDSC_CNT_W-1:0]   q_issue_cnt_ff;
    reg  [`FDSC_PTR_W-1:0]   wb_wr_ff;
    reg  [`FDSC_PTR_W-1:0]   wb_rd_ff;
    reg  [`FDSC_CNT_W-1:0]   wb_cnt_ff;
    reg  [1:0]               state_ff;

    // Next values
    reg  [`FDSC_PTR_W-1:0]   nxt_q_wr;
    reg  [`FDSC_PTR_W-1:0]   nxt_q_rd;
    reg  [`FDSC_PTR_W-1:0]   nxt_q_sent;
    reg  [`FDSC_CNT_W-1:0]   nxt_q_issue_cnt;
    reg  [`FDSC_CNT_W-1:0]   nxt_spec_level;
    reg  [`FDSC_PTR_W-1:0]   nxt_wb_wr;
    reg  [`FDSC_PTR_W-1:0]   nxt_wb_rd;
    reg  [`FDSC_CNT_W-1:0]   nxt_wb_cnt;
    reg  [1:0]               nxt_state;
    reg                      nxt_spec_halt;
    reg                      nxt_fu_valid;
    reg  [`FDSC_INSN_W-1:0]  nxt_fu_insn;
    reg  [`FDSC_DATA_W-1:0]  nxt_fu_operand;
    reg                      nxt_ext_valid;
    reg  [`FDSC_ADDR_W-1:0]  nxt_ext_addr;
    reg  [`FDSC_DATA_W-1:0]  nxt_ext_data;
    reg  [`FDSC_STATE_W-1:0] nxt_restore_state;
    reg                      fu_load;

    // Request qualification
    wire                     halt_st  = (state_ff == ST_HALT);
    wire                     q_full   = (spec_level_ff == `FDSC_DEPTH);
    wire                     wb_full  = (wb_cnt_ff == `FDSC_DEPTH);
    wire                     stop_now = (dec_branch_or_float && q_full) || dec_fault ||
                                        wb_full || dec_unsaved_write;
    wire                     can_take = ac2_valid && ac2_primary_pipe &&
                                        !ac2_xlate_fault && !q_full &&
                                        !ac2_accept_ff && (state_ff != ST_RESTORE);
    wire                     fdone    = float_unit_done && (spec_level_ff != 3'h0);
    wire                     fexc     = fdone && float_unit_exc;
    wire                     take     = can_take && !fexc;
    wire                     send     = float_unit_valid_ff && float_unit_ready;
    // Oldest buffered write may leave once all floats older than it completed
    wire                     wb_head_ok = (wb_cnt_ff != 3'h0) &&
                                          (wb_tag_ff[wb_rd_ff] == 3'h0);
    wire                     wb_pop   = wb_head_ok && (!ext_wr_valid_ff || ext_wr_ready) &&
                                        !fexc;
    wire                     wb_push  = wr_valid && !wb_full && !wr_accept_ff && !fexc &&
                                        !restore_ff;
    wire [3:0]               q_we;
    wire [3:0]               wb_we;
    integer                  i;

    // Per-entry write enables
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_we
            localparam [`FDSC_PTR_W-1:0] IDX = g;
            assign q_we[g]  = take && (q_wr_ff == IDX);
            assign wb_we[g] = wb_push && (wb_wr_ff == IDX);
        end
    endgenerate

    // Halt holds until the level drains; restore clears it
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN, ST_RESTORE: begin
                if (stop_now && !wb_full)
                    nxt_state = ST_HALT;
                else
                    nxt_state = ST_RUN;
            end
            ST_HALT: begin
                if (spec_level_ff != 3'h0 || (stop_now && !wb_full))
                    nxt_state = ST_HALT;
                else
                    nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
        if (fexc)
            nxt_state = ST_RESTORE;
    end

    always @* begin
        if (fexc)
            nxt_spec_halt = 1'b0;
        else
            nxt_spec_halt = stop_now || (halt_st && spec_level_ff != 3'h0);
    end

    // Issue queued ops to the float unit in order
    always @* begin
        fu_load        = (send || !float_unit_valid_ff) && (q_issue_cnt_ff != 3'h0) && !fexc;
        nxt_fu_valid   = float_unit_valid_ff;
        nxt_fu_insn    = float_unit_insn_ff;
        nxt_fu_operand = float_unit_operand_ff;
        nxt_q_sent     = q_sent_ff;
        if (fu_load) begin
            nxt_fu_valid   = 1'b1;
            nxt_fu_insn    = q_insn_ff[q_sent_ff];
            nxt_fu_operand = q_opnd_ff[q_sent_ff];
            nxt_q_sent     = q_sent_ff + 2'h1;
        end else if (send || fexc) begin
            nxt_fu_valid   = 1'b0;
        end
        if (fexc)
            nxt_q_sent = 2'h0;
    end

    // Queue pointers and speculation level
    always @* begin
        nxt_q_wr        = q_wr_ff;
        nxt_q_rd        = q_rd_ff;
        nxt_q_issue_cnt = q_issue_cnt_ff;
        nxt_spec_level  = spec_level_ff;
        if (fexc) begin
            nxt_q_wr        = 2'h0;
            nxt_q_rd        = 2'h0;
            nxt_q_issue_cnt = 3'h0;
            nxt_spec_level  = 3'h0;
        end else begin
            if (take)
                nxt_q_wr = q_wr_ff + 2'h1;
            if (fdone)
                nxt_q_rd = q_rd_ff + 2'h1;
            nxt_q_issue_cnt = q_issue_cnt_ff + (take ? 3'h1 : 3'h0)
                              - (fu_load ? 3'h1 : 3'h0);
            nxt_spec_level  = spec_level_ff + (take ? 3'h1 : 3'h0)
                              - (fdone ? 3'h1 : 3'h0);
        end
    end

    // Write buffer pointers
    always @* begin
        nxt_wb_wr  = wb_wr_ff;
        nxt_wb_rd  = wb_rd_ff;
        nxt_wb_cnt = wb_cnt_ff;
        if (fexc) begin
            nxt_wb_wr  = 2'h0;
            nxt_wb_rd  = 2'h0;
            nxt_wb_cnt = 3'h0;
        end else begin
            if (wb_push)
                nxt_wb_wr = wb_wr_ff + 2'h1;
            if (wb_pop)
                nxt_wb_rd = wb_rd_ff + 2'h1;
            nxt_wb_cnt = wb_cnt_ff + (wb_push ? 3'h1 : 3'h0) - (wb_pop ? 3'h1 : 3'h0);
        end
    end

    // External write stands until taken
    always @* begin
        nxt_ext_valid = ext_wr_valid_ff;
        nxt_ext_addr  = ext_wr_addr_ff;
        nxt_ext_data  = ext_wr_data_ff;
        if (wb_pop) begin
            nxt_ext_valid = 1'b1;
            nxt_ext_addr  = wb_addr_ff[wb_rd_ff];
            nxt_ext_data  = wb_data_ff[wb_rd_ff];
        end else if (ext_wr_ready) begin
            nxt_ext_valid = 1'b0;
        end
    end

    // Roll back to the oldest checkpoint
    always @* begin
        nxt_restore_state = restore_state_ff;
        if (fexc)
            nxt_restore_state = ckpt_ff[q_rd_ff];
    end

    // Entry storage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                q_insn_ff[i]  <= 32'h0;
                q_opnd_ff[i]  <= 64'h0;
                ckpt_ff[i]    <= 64'h0;
                wb_addr_ff[i] <= 32'h0;
                wb_data_ff[i] <= 64'h0;
                wb_tag_ff[i]  <= 3'h0;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (q_we[i]) begin
                    q_insn_ff[i] <= ac2_insn;
                    q_opnd_ff[i] <= ac2_operand;
                    ckpt_ff[i]   <= ac2_state;
                end
                // Writes tagged with floats outstanding; completions count down
                if (wb_we[i]) begin
                    wb_addr_ff[i] <= wr_addr;
                    wb_data_ff[i] <= wr_data;
                    wb_tag_ff[i]  <= spec_level_ff - (fdone ? 3'h1 : 3'h0);
                end else if (fdone && !fexc && wb_tag_ff[i] != 3'h0) begin
                    wb_tag_ff[i]  <= wb_tag_ff[i] - 3'h1;
                end
            end
        end
    end

    // Control registers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_wr_ff               <= 2'h0;
            q_rd_ff               <= 2'h0;
            q_sent_ff             <= 2'h0;
            q_issue_cnt_ff        <= 3'h0;
            spec_level_ff         <= 3'h0;
            wb_wr_ff              <= 2'h0;
            wb_rd_ff              <= 2'h0;
            wb_cnt_ff             <= 3'h0;
            state_ff              <= ST_RUN;
            ac2_accept_ff         <= 1'b0;
            ac2_fault_ff          <= 1'b0;
            wr_accept_ff          <= 1'b0;
            spec_halt_ff          <= 1'b0;
            float_unit_valid_ff   <= 1'b0;
            float_unit_insn_ff    <= 32'h0;
            float_unit_operand_ff <= 64'h0;
            ext_wr_valid_ff       <= 1'b0;
            ext_wr_addr_ff        <= 32'h0;
            ext_wr_data_ff        <= 64'h0;
            restore_ff            <= 1'b0;
            restore_state_ff      <= 64'h0;
            exc_report_ff         <= 1'b0;
        end else begin
            q_wr_ff               <= nxt_q_wr;
            q_rd_ff               <= nxt_q_rd;
            q_sent_ff             <= nxt_q_sent;
            q_issue_cnt_ff        <= nxt_q_issue_cnt;
            spec_level_ff         <= nxt_spec_level;
            wb_wr_ff              <= nxt_wb_wr;
            wb_rd_ff              <= nxt_wb_rd;
            wb_cnt_ff             <= nxt_wb_cnt;
            state_ff              <= nxt_state;
            ac2_accept_ff         <= take;
            ac2_fault_ff          <= ac2_valid && ac2_primary_pipe && ac2_xlate_fault &&
                                     !ac2_fault_ff;
            wr_accept_ff          <= wb_push;
            spec_halt_ff          <= nxt_spec_halt;
            float_unit_valid_ff   <= nxt_fu_valid;
            float_unit_insn_ff    <= nxt_fu_insn;
            float_unit_operand_ff <= nxt_fu_operand;
            ext_wr_valid_ff       <= nxt_ext_valid;
            ext_wr_addr_ff        <= nxt_ext_addr;
            ext_wr_data_ff        <= nxt_ext_data;
            restore_ff            <= fexc;
            restore_state_ff      <= nxt_restore_state;
            exc_report_ff         <= fexc;
        end
    end
endmodule // fdsc_ctrl
`default_nettype wire

// [fdsc_ctrl_props.sv]
/* Assertions on the fdsc_ctrl ports. Assumes binding by port name. */
`timescale 1ns/1ps
`default_nettype none
module fdsc_props (
    // Watched ports
    input wire logic        clk, arst_n, ac2_valid, ac2_primary_pipe, ac2_xlate_fault,
    input wire logic        ac2_accept_ff, ac2_fault_ff, dec_branch_or_float, dec_fault,
    input wire logic        dec_unsaved_write, spec_halt_ff, float_unit_done, float_unit_exc,
    input wire logic        float_unit_valid_ff, float_unit_ready, ext_wr_valid_ff,
    input wire logic        ext_wr_ready, restore_ff, exc_report_ff,
    input wire logic [2:0]  spec_level_ff,
    input wire logic [31:0] float_unit_insn_ff, ext_wr_addr_ff,
    input wire logic [63:0] ext_wr_data_ff
);
default clocking cb @(posedge clk); endclocking
default disable iff (!arst_n);
a_level_max: assert property (spec_level_ff <= 3'h4) else $error("level above four");
a_accept_cause: assert property (ac2_accept_ff |->
    $past(ac2_valid && ac2_primary_pipe && !ac2_xlate_fault && spec_level_ff < 3'h4))
    else $error("queued without cause");
a_fault_answer: assert property (ac2_fault_ff |-> $past(ac2_xlate_fault) && !ac2_accept_ff)
    else $error("fault answer without fault");
a_done_level: assert property (float_unit_done && !float_unit_exc && spec_level_ff != 3'h0
    |=> ac2_accept_ff || spec_level_ff == $past(spec_level_ff) - 3'h1) else $error("no decrement");
a_exc_restore: assert property (float_unit_done && float_unit_exc && spec_level_ff != 3'h0
    |=> restore_ff && exc_report_ff && spec_level_ff == 3'h0) else $error("no restore");
a_halt_stop: assert property (dec_fault || dec_unsaved_write
    || (dec_branch_or_float && spec_level_ff == 3'h4) |=> spec_halt_ff) else $error("no halt");
a_ext_hold: assert property (ext_wr_valid_ff && !ext_wr_ready && !float_unit_done
    |=> ext_wr_valid_ff && $stable(ext_wr_addr_ff) && $stable(ext_wr_data_ff))
    else $error("write dropped");
a_issue_hold: assert property (float_unit_valid_ff && !float_unit_ready && !float_unit_done
    |=> float_unit_valid_ff && $stable(float_unit_insn_ff)) else $error("issue dropped");
c_full: cover property (ac2_accept_ff && spec_level_ff == 3'h4);
c_restore: cover property (restore_ff);
c_ext: cover property (ext_wr_valid_ff && ext_wr_ready);
endmodule // fdsc_props
bind fdsc_ctrl fdsc_props u_props (.*);
`default_nettype wire

// [fdsc_float_model.sv]
/* Float unit and external write sink model. Assumes bench-driven stall and fault. */
`timescale 1ns/1ps
`default_nettype none
module fdsc_float_model (
    // Clock, reset and bench controls
    input wire logic clk, arst_n, slow, exc_req,
    // Design side
    input wire logic valid, restore,
    output var logic ready, done, exc, ext_ready
);
logic [7:0] lfsr_ff;
logic [2:0] cnt_ff;
logic       fin;
always_comb fin = !slow && lfsr_ff[2] && cnt_ff != 3'h0;
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        {lfsr_ff, cnt_ff, ready, done, exc, ext_ready} <= {8'h5a, 7'h0};
    end else begin
        lfsr_ff   <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
        ready     <= !slow && lfsr_ff[0];
        ext_ready <= lfsr_ff[1];
        done      <= fin;
        exc       <= fin && exc_req;
        cnt_ff    <= restore ? 3'h0 : cnt_ff + {2'h0, valid && ready} - {2'h0, fin};
    end
end
endmodule // fdsc_float_model
`default_nettype wire

// [tb_float_dispatch_speculation_ctrl.sv]
/* Bench for fdsc_ctrl. Assumes fdsc_float_model stands at the far side. */
`timescale 1ns/1ps
`default_nettype none
module tb_float_dispatch_speculation_ctrl;
logic clk, arst_n, ac2_valid, ac2_primary_pipe, ac2_xlate_fault, ac2_accept_ff, ac2_fault_ff;
logic dec_branch_or_float, dec_unsaved_write, dec_fault, spec_halt_ff, wr_valid, wr_accept_ff;
logic float_unit_valid_ff, float_unit_ready, float_unit_done, float_unit_exc, ext_wr_valid_ff;
logic ext_wr_ready, restore_ff, exc_report_ff, slow, exc_req;
logic [1:0]  res;
logic [2:0]  spec_level_ff;
logic [31:0] ac2_insn, wr_addr, float_unit_insn_ff, ext_wr_addr_ff, seed;
logic [63:0] ac2_operand, ac2_state, wr_data, float_unit_operand_ff, ext_wr_data_ff;
logic [63:0] restore_state_ff, st;
logic [95:0] exp_q[$], fq[$];
int          mismatches = 0, n_compared = 0;
fdsc_ctrl DUT (.*);
fdsc_float_model u_fu (.clk(clk), .arst_n(arst_n), .slow(slow), .exc_req(exc_req),
    .valid(float_unit_valid_ff), .restore(restore_ff), .ready(float_unit_ready),
    .done(float_unit_done), .exc(float_unit_exc), .ext_ready(ext_wr_ready));
function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
endfunction
task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
        mismatches++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic results;
    if (mismatches == 0 && n_compared > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
task automatic ac2_op(input logic prim, input logic flt, output logic [1:0] r);
    seed = xs(seed);
    {ac2_insn, ac2_operand, ac2_state} = {seed, ~seed, seed, seed, ~seed};
    {ac2_primary_pipe, ac2_xlate_fault, ac2_valid, r} = {prim, flt, 3'h4};
    for (int i = 0; i < 6 && r == 2'h0; i++) begin
        @(posedge clk);
        #1 r = {ac2_fault_ff, ac2_accept_ff};
    end
    if (r == 2'h1)
        fq.push_back({ac2_insn, ac2_operand});
    ac2_valid = 1'b0;
    @(posedge clk);
    #1;
endtask
task automatic wr_op;
    seed = xs(seed);
    {wr_addr, wr_data, wr_valid} = {seed, ~seed, seed, 1'b1};
    exp_q.push_back({wr_addr, wr_data});
    for (int i = 0; i < 6 && wr_accept_ff !== 1'b1; i++) begin
        @(posedge clk);
        #1;
    end
    check(wr_accept_ff, 1'b1);
    wr_valid = 1'b0;
    @(posedge clk);
    #1;
endtask
// Ordered external writes against the expected queue
always @(negedge clk) if (ext_wr_valid_ff === 1'b1 && ext_wr_ready === 1'b1)
    check({ext_wr_addr_ff, ext_wr_data_ff}, exp_q.pop_front());
// Issued float ops in queue order, with their operands
always @(negedge clk) if (float_unit_valid_ff === 1'b1 && float_unit_ready === 1'b1)
    check({float_unit_insn_ff, float_unit_operand_ff}, fq.pop_front());
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
end
initial begin
    {arst_n, ac2_valid, ac2_primary_pipe, ac2_xlate_fault, dec_branch_or_float} = 5'h0;
    {dec_unsaved_write, dec_fault, wr_valid, exc_req, slow} = 5'h1;
    {ac2_insn, wr_addr, ac2_operand, ac2_state, wr_data} = 256'h0;
    seed = 32'h43c6;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    ac2_op(1'b0, 1'b0, res);
    check(res, 2'h0);
    ac2_op(1'b1, 1'b1, res);
    check(res, 2'h2);
    for (int k = 0; k < 4; k++) begin
        ac2_op(1'b1, 1'b0, res);
        check(res, 2'h1);
    end
    check(spec_level_ff, 3'h4);
    ac2_op(1'b1, 1'b0, res);
    check(res, 2'h0);
    dec_branch_or_float = 1'b1;
    @(posedge clk);
    #1 dec_branch_or_float = 1'b0;
    check(spec_halt_ff, 1'b1);
    repeat (4) wr_op();
    check({exp_q.size(), ext_wr_valid_ff}, {32'd4, 1'b0});
    slow = 1'b0;
    for (int i = 0; i < 300 && (spec_level_ff !== 3'h0 || exp_q.size() != 0); i++)
        @(posedge clk);
    #1 check({exp_q.size(), spec_level_ff}, 3'h0);
    check(spec_halt_ff, 1'b0);
    exc_req = 1'b1;
    ac2_op(1'b1, 1'b0, res);
    st = ac2_state;
    for (int i = 0; i < 100 && restore_ff !== 1'b1; i++) begin
        @(posedge clk);
        #1;
    end
    check({restore_ff, exc_report_ff, restore_state_ff}, {2'h3, st});
    exc_req = 1'b0;
    results();
end
endmodule // tb_float_dispatch_speculation_ctrl
`default_nettype wire
